// ### core/iab_timing.sv
// two-wire bus own address, bit-rate timing and start/byte/stop sequencer
`timescale 1ns/100ps
// How it works
// [RL1] the clock line is open drain: we sense it and may pull it low.
// [RL2] the data line is open drain: we sense it and may pull it low.
// [RL3] the own address sits in bits 7..1 and is compared with the address byte after every start seen on the bus, our own included.
// [RL4] a 7-bit address matches whole; after a 10-bit header it matches the low seven bits.
// [RL5] bits 7..6 pick multiplier 1, 2 or 4, with the last code reserved.
// [RL6] bits 5..0 look up divider, data hold, start hold and stop hold counts.
// [RL7] one bit lasts multiplier times divider clocks.
// [RL8] data changes multiplier times data hold clocks after the clock falls.
// [RL9] the clock falls multiplier times start hold clocks after data falls at a start.
// [RL10] data rises multiplier times stop hold clocks after the clock rises at a stop.
// [RL11] codes 0x00..0x0f use dividers 20 up to 68 with their hold counts.
// [RL12] codes 0x10..0x1f use dividers 48 up to 240 with their hold counts.
// [RL13] with the enable bit clear the controller is idle and lets both lines go.
// [RL14] delays are counted in bus clocks from their first edge; new rates apply per bit.
module iab_timing
    import iab_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    typedef enum logic [2:0] {S_IDLE, S_STA, S_PARK, S_LOW, S_HIGH, S_SPL, S_SPH} iab_seq_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] rate;
        logic [7:0] ctrl;
        logic [7:0] txd;
        logic [7:0] rdata;
        iab_seq_t seq;
        logic [15:0] cnt;
        logic [3:0] bitn;
        logic [7:0] shift;
        logic [1:0] mul_sh;
        iab_timing_t tim;
        logic scl_oe;
        logic sda_oe;
        logic scl_out;
        logic sda_out;
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic scl_p;
        logic sda_p;
        logic armed;
        logic [3:0] s_cnt;
        logic [7:0] s_sh;
        logic s_second;
        logic ten;
        logic match;
        logic nack;
    } iab_state_t;

    iab_state_t s;
    iab_state_t n;

    logic en;
    logic wr_ctrl;
    logic cmd_start;
    logic cmd_stop;
    logic cmd_byte;
    logic [15:0] lim_sda;
    logic [15:0] lim_sta;
    logic [15:0] lim_stp;
    logic [15:0] lim_per;
    logic [15:0] lim_half;
    logic [15:0] lim_high;
    logic scl_rise;
    logic bus_start;
    logic bus_stop;
    logic [7:0] s_byte;
    iab_timing_t new_tim;

    // fixed table rows watched by the table checks
    wire iab_timing_t row_0f = iab_lookup(6'h0f);
    wire iab_timing_t row_00 = iab_lookup(6'h00);
    wire iab_timing_t row_1f = iab_lookup(6'h1f);
    wire iab_timing_t row_3f = iab_lookup(6'h3f);

    // command strobes exist only in the write cycle; those bits read back as zero
    assign en = s.ctrl[IAB_CTRL_EN];
    assign wr_ctrl = reg_wr_i && (reg_addr_i == IAB_OFS_CTRL);
    assign cmd_start = wr_ctrl && reg_wdata_i[IAB_CTRL_EN] && reg_wdata_i[IAB_CTRL_START];
    assign cmd_stop = wr_ctrl && reg_wdata_i[IAB_CTRL_EN] && reg_wdata_i[IAB_CTRL_STOP];
    assign cmd_byte = wr_ctrl && reg_wdata_i[IAB_CTRL_EN] && reg_wdata_i[IAB_CTRL_BYTE];

    // phase lengths from the latched multiplier and table row
    assign new_tim = iab_lookup(s.rate[IAB_CODE_HI:0]); // RL6 RL11 RL12
    assign lim_sda = iab_scale(s.tim.sda, s.mul_sh); // RL8
    assign lim_sta = iab_scale(s.tim.sta, s.mul_sh); // RL9
    assign lim_stp = iab_scale(s.tim.stp, s.mul_sh); // RL10
    assign lim_per = iab_scale(s.tim.div, s.mul_sh); // RL7
    assign lim_half = {1'b0, lim_per[15:1]};
    assign lim_high = lim_per - lim_half;

    // bus watcher works only on the second synchroniser stage and its delayed copy
    assign scl_rise = s.scl_s2 && !s.scl_p;
    assign bus_start = s.scl_s2 && s.scl_p && s.sda_p && !s.sda_s2;
    assign bus_stop = s.scl_s2 && s.scl_p && !s.sda_p && s.sda_s2;
    assign s_byte = {s.s_sh[6:0], s.sda_s2};

    always_comb begin
        n = s;
        // two-stage synchronisers on the sensed lines
        n.scl_s1 = scl_i; // RL1
        n.scl_s2 = s.scl_s1;
        n.sda_s1 = sda_i; // RL2
        n.sda_s2 = s.sda_s1;
        n.scl_p = s.scl_s2;
        n.sda_p = s.sda_s2;
        // open drain: the driven level is always low, only the enables move
        n.scl_out = 1'b0;
        n.sda_out = 1'b0;

        // register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                IAB_OFS_ADDR: n.addr = {reg_wdata_i[7:1], 1'b0}; // RL3
                IAB_OFS_RATE: n.rate = reg_wdata_i;
                IAB_OFS_CTRL: n.ctrl = reg_wdata_i & (8'h01 << IAB_CTRL_EN);
                IAB_OFS_TXD: n.txd = reg_wdata_i;
                IAB_OFS_STAT: begin
                    if (reg_wdata_i[IAB_STAT_MATCH]) n.match = 1'b0;
                    if (reg_wdata_i[IAB_STAT_NACK]) n.nack = 1'b0;
                end
                default: ;
            endcase
        end

        // read data stands the cycle after the strobe, zero otherwise
        n.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                IAB_OFS_ADDR: n.rdata = s.addr;
                IAB_OFS_RATE: n.rdata = s.rate;
                IAB_OFS_CTRL: n.rdata = s.ctrl;
                IAB_OFS_TXD: n.rdata = s.txd;
                IAB_OFS_STAT: begin
                    n.rdata[IAB_STAT_BUSY] = (s.seq != S_IDLE) && (s.seq != S_PARK);
                    n.rdata[IAB_STAT_MATCH] = s.match;
                    n.rdata[IAB_STAT_NACK] = s.nack;
                    n.rdata[IAB_STAT_BUS] = s.armed;
                end
                default: n.rdata = 8'h00;
            endcase
        end

        // address watcher: shift on clock rise, judge after eight bits
        if (bus_start) begin
            n.armed = 1'b1;
            n.s_cnt = 4'h0;
            n.s_second = 1'b0;
            n.ten = 1'b0;
        end else if (bus_stop) begin
            n.armed = 1'b0;
        end else if (s.armed && scl_rise) begin
            if (s.s_cnt == IAB_ACK_BIT) begin
                n.s_cnt = 4'h0;
                n.s_second = 1'b1;
            end else begin
                n.s_sh = s_byte;
                n.s_cnt = s.s_cnt + 4'h1;
                if (s.s_cnt == IAB_ACK_BIT - 4'h1) begin
                    if (!s.s_second && s_byte[7:3] == IAB_TEN_HDR) begin
                        n.ten = 1'b1; // RL4
                    end else if (!s.s_second && s_byte[7:1] == s.addr[7:1]) begin
                        n.match = 1'b1; // RL3 RL4
                    end else if (s.s_second && s.ten && s_byte[6:0] == s.addr[7:1]) begin
                        n.match = 1'b1; // RL4
                    end
                end
            end
        end

        // sequencer; counts start at zero on the edge that opens each delay
        n.cnt = s.cnt + 16'h0001; // RL14
        case (s.seq)
            S_IDLE: begin
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
                if (cmd_start) begin
                    n.tim = new_tim;
                    n.mul_sh = iab_mul_shift(s.rate[IAB_RATE_MULTIPLIER_SELECT_HI:IAB_RATE_MULTIPLIER_SELECT_LO]); // RL5
                    n.sda_oe = 1'b1; // RL2
                    n.cnt = 16'h0000;
                    n.seq = S_STA;
                end
            end
            S_STA: begin
                if (s.cnt == lim_sta - 16'h0001) begin
                    n.scl_oe = 1'b1; // RL9
                    n.seq = S_PARK;
                end
            end
            S_PARK: begin
                // a fresh rate takes hold here as well as at the start and after each data bit in S_HIGH
                n.cnt = 16'h0000;
                if (cmd_byte || cmd_stop) begin
                    n.tim = new_tim; // RL14
                    n.mul_sh = iab_mul_shift(s.rate[IAB_RATE_MULTIPLIER_SELECT_HI:IAB_RATE_MULTIPLIER_SELECT_LO]);
                    n.bitn = 4'h0;
                    n.shift = s.txd;
                    n.seq = cmd_byte ? S_LOW : S_SPL;
                end
            end
            S_LOW: begin
                n.scl_oe = 1'b1;
                if (s.cnt == lim_sda - 16'h0001) begin
                    n.sda_oe = (s.bitn == IAB_ACK_BIT) ? 1'b0 : !s.shift[7]; // RL8
                end
                if (s.cnt == lim_half - 16'h0001) begin
                    n.scl_oe = 1'b0; // RL1
                    n.cnt = 16'h0000;
                    n.seq = S_HIGH;
                end
            end
            S_HIGH: begin
                // no stretch wait: the bit length stays exact, a slow target is not served
                if (s.cnt == lim_high - 16'h0001) begin
                    n.scl_oe = 1'b1; // RL7
                    n.cnt = 16'h0000;
                    n.shift = {s.shift[6:0], 1'b0};
                    if (s.bitn == IAB_ACK_BIT) begin
                        n.nack = s.nack | s.sda_s2;
                        n.seq = S_PARK;
                    end else begin
                        n.bitn = s.bitn + 4'h1;
                        n.tim = new_tim; // RL14
                        n.mul_sh = iab_mul_shift(s.rate[IAB_RATE_MULTIPLIER_SELECT_HI:IAB_RATE_MULTIPLIER_SELECT_LO]);
                        n.seq = S_LOW;
                    end
                end
            end
            S_SPL: begin
                n.scl_oe = 1'b1;
                if (s.cnt == lim_sda - 16'h0001) begin
                    n.sda_oe = 1'b1;
                end
                if (s.cnt == lim_half - 16'h0001) begin
                    n.scl_oe = 1'b0;
                    n.cnt = 16'h0000;
                    n.seq = S_SPH;
                end
            end
            S_SPH: begin
                if (s.cnt == lim_stp - 16'h0001) begin
                    n.sda_oe = 1'b0; // RL10
                    n.seq = S_IDLE;
                end
            end
            default: n.seq = S_IDLE;
        endcase

        // disabled: sequencer back to S_IDLE, watcher disarmed and both lines let go; the enable being written
        // counts, so a start in the same write as the enable is not lost
        if (!n.ctrl[IAB_CTRL_EN]) begin
            n.seq = S_IDLE; // RL13
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.armed = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            s <= '0;
            s.addr <= IAB_RST_ADDR;
            s.rate <= IAB_RST_RATE;
            s.ctrl <= IAB_RST_CTRL;
            s.txd <= IAB_RST_TXD;
            s.seq <= S_IDLE;
            s.scl_s1 <= 1'b1;
            s.scl_s2 <= 1'b1;
            s.sda_s1 <= 1'b1;
            s.sda_s2 <= 1'b1;
            s.scl_p <= 1'b1;
            s.sda_p <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata_o = s.rdata;
    assign scl_o = s.scl_out;
    assign scl_oe_o = s.scl_oe;
    assign sda_o = s.sda_out;
    assign sda_oe_o = s.sda_oe;

    chk_start_hold: assert property (@(posedge clock_i) disable iff (reset_i) // RL9
        (en && s.seq == S_STA && s.cnt < lim_sta - 16'h0001) |=> (sda_oe_o && !scl_oe_o))
        else $error("clock fell before start hold ended");
    chk_start_fall: assert property (@(posedge clock_i) disable iff (reset_i) // RL9
        (en && s.seq == S_STA && s.cnt == lim_sta - 16'h0001) |=> (scl_oe_o && sda_oe_o))
        else $error("clock not pulled low at end of start hold");
    chk_data_hold: assert property (@(posedge clock_i) disable iff (reset_i) // RL8
        (en && s.seq == S_LOW && s.cnt < lim_sda - 16'h0001) |=> $stable(sda_oe_o))
        else $error("data moved inside data hold");
    chk_stop_hold: assert property (@(posedge clock_i) disable iff (reset_i) // RL10
        (en && s.seq == S_SPH && s.cnt < lim_stp - 16'h0001) |=> (sda_oe_o && !scl_oe_o))
        else $error("data released before stop hold ended");
    chk_high_len: assert property (@(posedge clock_i) disable iff (reset_i) // RL7
        (en && s.seq == S_LOW && s.cnt == lim_half - 16'h0001) |=> !scl_oe_o [*2])
        else $error("clock high phase cut short");
    chk_rate_multiplier_select_map: assert property (@(posedge clock_i) disable iff (reset_i) // RL5
        (s.seq == S_STA && $past(s.seq) == S_IDLE) |->
        (lim_per == ($past(s.rate[7:6]) == 2'b10 ? 16'h0004 : $past(s.rate[7:6]) == 2'b01 ?
        16'h0002 : 16'h0001) * $past(new_tim.div)))
        else $error("bit period differs from multiplier times divider");
    chk_lut_low: assert property (@(posedge clock_i) disable iff (reset_i) // RL11
        row_0f.div == 16'h0044 && row_00.stp == 16'h000b)
        else $error("low rate table row wrong");
    chk_lut_high: assert property (@(posedge clock_i) disable iff (reset_i) // RL12
        row_1f.div == 16'h00f0 && row_3f.sta == 16'h077e)
        else $error("high rate table row wrong");
    chk_disable_idle: assert property (@(posedge clock_i) disable iff (reset_i) // RL13
        !en |-> (!scl_oe_o && !sda_oe_o && s.seq == S_IDLE))
        else $error("lines held while disabled");
endmodule : iab_timing

// ### core/iab_pkg.sv
// register map, field layout and bit-rate tables of the two-wire timing block
package iab_pkg;
    // register offsets on the plain register port
    localparam logic [2:0] IAB_OFS_ADDR = 3'h0;
    localparam logic [2:0] IAB_OFS_RATE = 3'h1;
    localparam logic [2:0] IAB_OFS_CTRL = 3'h2;
    localparam logic [2:0] IAB_OFS_TXD = 3'h3;
    localparam logic [2:0] IAB_OFS_STAT = 3'h4;
    // field positions
    localparam int IAB_RATE_MULTIPLIER_SELECT_HI = 7;
    localparam int IAB_RATE_MULTIPLIER_SELECT_LO = 6;
    localparam int IAB_CODE_HI = 5;
    localparam int IAB_CTRL_EN = 7;
    localparam int IAB_CTRL_START = 0;
    localparam int IAB_CTRL_STOP = 1;
    localparam int IAB_CTRL_BYTE = 2;
    localparam int IAB_STAT_BUSY = 0;
    localparam int IAB_STAT_MATCH = 1;
    localparam int IAB_STAT_NACK = 2;
    localparam int IAB_STAT_BUS = 3;
    // values after reset
    localparam logic [7:0] IAB_RST_ADDR = 8'h00;
    localparam logic [7:0] IAB_RST_RATE = 8'h00;
    localparam logic [7:0] IAB_RST_CTRL = 8'h00;
    localparam logic [7:0] IAB_RST_TXD = 8'h00;
    // first-byte header of a 10-bit address
    localparam logic [4:0] IAB_TEN_HDR = 5'h1e;
    // data bits plus acknowledge slot
    localparam logic [3:0] IAB_ACK_BIT = 4'h8;
    // divider and hold counts for rate codes 0x00..0x1f
    localparam int IAB_DIV [32] = '{20, 22, 24, 26, 28, 30, 34, 40, 28, 32, 36, 40, 44, 48,
        56, 68, 48, 56, 64, 72, 80, 88, 104, 128, 80, 96, 112, 128, 144, 160, 192, 240};
    localparam int IAB_SDA [32] = '{7, 7, 8, 8, 9, 9, 10, 10, 7, 7, 9, 9, 11, 11, 13, 13,
        9, 9, 13, 13, 17, 17, 21, 21, 9, 9, 17, 17, 25, 25, 33, 33};
    localparam int IAB_STA [32] = '{6, 7, 8, 9, 10, 11, 13, 16, 10, 12, 14, 16, 18, 20, 24,
        30, 18, 22, 26, 30, 34, 38, 46, 58, 38, 46, 54, 62, 70, 78, 94, 118};
    localparam int IAB_STP [32] = '{11, 12, 13, 14, 15, 16, 18, 21, 15, 17, 19, 21, 23, 25,
        29, 35, 25, 29, 33, 37, 41, 45, 53, 65, 41, 49, 57, 65, 73, 81, 97, 121};

    typedef struct packed {
        logic [15:0] div;
        logic [15:0] sda;
        logic [15:0] sta;
        logic [15:0] stp;
    } iab_timing_t;

    // upper codes double the row eight codes below, hold counts follow suit
    function automatic iab_timing_t iab_lookup(input logic [5:0] code);
        iab_timing_t t;
        logic [4:0] idx;
        idx = code[5] ? {2'b11, code[2:0]} : code[4:0];
        t.div = 16'(IAB_DIV[idx]);
        t.sda = 16'(IAB_SDA[idx]);
        t.sta = 16'(IAB_STA[idx]);
        t.stp = 16'(IAB_STP[idx]);
        for (int i = 0; i < 4; i++) begin
            if (code[5] && (i <= int'(code[4:3]))) begin
                t.div = t.div << 1;
                t.sda = (t.sda << 1) - 16'h0001;
                t.sta = (t.sta << 1) + 16'h0002;
                t.stp = t.sta + 16'h0003;
            end
        end
        return t;
    endfunction : iab_lookup

    // multiplier as a shift: 1, 2, 4; reserved code runs as 1
    function automatic logic [1:0] iab_mul_shift(input logic [1:0] code);
        case (code)
            2'b01: return 2'h1;
            2'b10: return 2'h2;
            default: return 2'h0;
        endcase
    endfunction : iab_mul_shift

    function automatic logic [15:0] iab_scale(input logic [15:0] v, input logic [1:0] sh);
        return v << sh;
    endfunction : iab_scale
endpackage : iab_pkg

// ### test/iab_bus_partner.sv
// far-side target on the two-wire bus: counts bits and may acknowledge
`timescale 1ns/100ps
module iab_bus_partner (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic ack_en_i,
    output logic sda_pull_o
);
    int bit_cnt;

    initial begin
        bit_cnt = 0;
        sda_pull_o = 1'b0;
    end

    // start seen on the wire: data falls with clock high
    always @(negedge sda_i) begin
        if (scl_i) begin
            bit_cnt = 0;
        end
    end

    // each clock rise ends one bit on the wire
    always @(posedge scl_i) begin
        bit_cnt = bit_cnt + 1;
    end

    // only pulls low, never drives high: open drain like any party
    always @(negedge scl_i) begin
        sda_pull_o <= ack_en_i && (bit_cnt % 9 == 8);
    end
endmodule : iab_bus_partner

// ### test/tb_top.sv
// self-checking bench for the two-wire address and bit-rate block
`timescale 1ns/100ps
module tb_top
    import iab_pkg::*;
;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o;
    logic ack_pull, ack_en = 1'b1;
    int n_mismatch = 0;
    int cmp_count = 0;
    // wired levels with pull-ups: low while any party pulls
    wire scl_w = !scl_oe_o;
    wire sda_w = !(sda_oe_o || ack_pull);

    always #50 clock_i = !clock_i;

    iab_timing u_dut (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
    iab_bus_partner u_partner (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en),
        .sda_pull_o(ack_pull));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
        // let the edge that took the write settle before anyone looks
        #1;
    endtask : reg_wr

    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        // read data stand only in this cycle; take them mid-cycle
        @(negedge clock_i);
        d = reg_rdata_o;
    endtask : reg_rd

    // counts clock edges until a pull enable reaches a level; bounded
    task automatic wait_oe(input int which, input logic lvl, output int n);
        n = 0;
        while (((which == 0) ? scl_oe_o : sda_oe_o) !== lvl && n < 5000) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (n >= 5000) begin
            n_mismatch++;
        end
    endtask : wait_oe

    task automatic test_regs;
        logic [7:0] rd;
        reg_rd(IAB_OFS_ADDR, rd);
        check("address after reset", 16'(rd), 16'(IAB_RST_ADDR));
        reg_rd(IAB_OFS_RATE, rd);
        check("rate after reset", 16'(rd), 16'(IAB_RST_RATE));
        reg_wr(IAB_OFS_ADDR, 8'hab);
        reg_rd(IAB_OFS_ADDR, rd);
        check("own address", 16'(rd), 16'h00aa);
        reg_wr(IAB_OFS_RATE, 8'hc7);
        reg_rd(IAB_OFS_RATE, rd);
        check("rate register", 16'(rd), 16'h00c7);
        reg_rd(3'h7, rd);
        check("unmapped read", 16'(rd), 16'h0000);
        $display("test registers done");
    endtask : test_regs

    // start hold for one multiplier and rate code; optionally left parked
    task automatic test_start(input logic [1:0] mc, input logic [5:0] code, input int sta,
        input bit keep);
        int m, n;
        m = (mc == 2'b01) ? 2 : (mc == 2'b10) ? 4 : 1;
        reg_wr(IAB_OFS_RATE, {mc, code});
        reg_wr(IAB_OFS_CTRL, 8'h81);
        wait_oe(1, 1'b1, n);
        check("start data fall", 16'(n), 16'h0000);
        wait_oe(0, 1'b1, n);
        check("start hold", 16'(n), 16'(m * sta));
        check("driven levels", {14'h0000, scl_o, sda_o}, 16'h0000);
        if (!keep) begin
            reg_wr(IAB_OFS_CTRL, 8'h00);
            @(posedge clock_i);
            #1;
            check("released lines", {14'h0000, scl_oe_o, sda_oe_o}, 16'h0000);
        end
        $display("test start hold done");
    endtask : test_start

    // alternating bytes change data every data bit, so each data-bit hold is visible
    task automatic send_byte(input logic [7:0] d, input int m, input int div, input int sdh);
        int p, h, n, dh;
        logic lv;
        p = m * div;
        h = p / 2;
        reg_wr(IAB_OFS_TXD, d);
        reg_wr(IAB_OFS_CTRL, 8'h84);
        for (int i = 8; i >= 0; i--) begin
            lv = (i == 0) ? 1'b0 : !d[i-1];
            // a last data bit of one leaves the line released: no move to see
            dh = (i == 0 && d[0]) ? 0 : m * sdh;
            wait_oe(1, lv, n);
            check("data hold", 16'(n), 16'(dh));
            wait_oe(0, 1'b0, n);
            check("clock low time", 16'(n), 16'(h - dh));
            wait_oe(0, 1'b1, n);
            check("clock high time", 16'(n), 16'(p - h));
        end
        $display("test byte done");
    endtask : send_byte

    task automatic send_stop(input int m, input int div, input int sdh, input int stp);
        int n;
        reg_wr(IAB_OFS_CTRL, 8'h82);
        wait_oe(1, 1'b1, n);
        check("stop data low", 16'(n), 16'(m * sdh));
        wait_oe(0, 1'b0, n);
        check("stop clock rise", 16'(n), 16'(m * div / 2 - m * sdh));
        wait_oe(1, 1'b0, n);
        check("stop hold", 16'(n), 16'(m * stp));
        $display("test stop done");
    endtask : send_stop

    // bus seen, nack, match, sequencer busy
    task automatic check_status(input logic [3:0] exp);
        logic [7:0] rd;
        reg_rd(IAB_OFS_STAT, rd);
        check("status flags", 16'(rd[3:0]), 16'(exp));
    endtask : check_status

    initial begin
        #5_000_000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clock_i);
        reset_i <= 1'b0;
        test_regs();
        test_start(2'b00, 6'h00, 6, 0);
        test_start(2'b10, 6'h14, 34, 0);
        test_start(2'b11, 6'h0f, 30, 0);
        test_start(2'b00, 6'h10, 18, 0);
        // seven-bit header equal to our own address, then a refused byte
        test_start(2'b01, 6'h07, 16, 1);
        send_byte(8'haa, 2, 40, 10);
        check_status(4'b1010);
        ack_en = 1'b0;
        send_byte(8'h55, 2, 40, 10);
        check_status(4'b1110);
        send_stop(2, 40, 10, 21);
        reg_wr(IAB_OFS_STAT, 8'h06);
        check_status(4'b0000);
        // ten-bit header, then low seven bits equal to our own address
        ack_en = 1'b1;
        test_start(2'b00, 6'h1f, 118, 1);
        reg_wr(IAB_OFS_TXD, 8'hf0);
        reg_wr(IAB_OFS_CTRL, 8'h84);
        repeat (9 * 240 + 4) @(posedge clock_i);
        send_byte(8'h55, 1, 240, 33);
        check_status(4'b1010);
        send_stop(1, 240, 33, 121);
        stop_test();
    end
endmodule : tb_top
